//--- hmdp_defs.vh
// Constants for the host memory DMA port.
// Assumes inclusion by bare name from the port's design files.
`ifndef HMDP_DEFS_VH
`define HMDP_DEFS_VH

`define HMDP_ADDR_W       14
`define HMDP_MEM_DEPTH    16384
`define HMDP_PM_W         24
`define HMDP_DM_W         16
`define HMDP_OVL_ADDR     14'h3fe0
`define HMDP_SADDR_ADDR   14'h3fe1
`define HMDP_TIM_ADDR     14'h3fe7
`define HMDP_CTRL_BASE    14'h3fe0
`define HMDP_OVL_BIT      15
`define HMDP_PMDM_BIT     14
`define HMDP_TIM_BIT      14
`define HMDP_BOOT_MODE    3'b101
`define HMDP_OVL_RESET    16'h0000
`define HMDP_TIM_RESET    16'h0000
`define HMDP_SYNC_W       20
`define HMDP_STRAP_WAIT   2'd2

`endif

//--- hmdp_sync.v
// Two-flop synchroniser for host port pins.
// Assumes inputs are asynchronous to core_clk.
module hmdp_sync
#(
	parameter W = 4
)
(
	input  wire         core_clk,
	input  wire         reset,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] stage1;

	// =====================================================
	// Two stages, first read only by second
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			stage1   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // hmdp_sync

//--- hmdp_port.v
// Host memory DMA port with on-chip program and data memory.
// Assumes an asynchronous host on the pins and a core on core_clk.
`include "hmdp_defs.vh"

module hmdp_port
(
	input  wire        core_clk,
	input  wire        reset,
	input  wire        port_select_n,
	input  wire        address_latch_strobe,
	input  wire        port_read_strobe_n,
	input  wire        port_write_strobe_n,
	input  wire [15:0] host_bus_in,
	output reg  [15:0] host_bus_out,
	output wire        host_bus_oe,
	output wire        port_acknowledge,
	input  wire        mode_a,
	input  wire        mode_b,
	input  wire        mode_c,
	input  wire [13:0] core_addr,
	input  wire        core_wr,
	input  wire        core_rd,
	input  wire [15:0] core_wdata,
	output reg  [15:0] core_rdata,
	output wire        core_wait,
	output wire        core_run
);

	localparam ST_IDLE   = 2'd0;
	localparam ST_ACCESS = 2'd1;
	localparam ST_REL    = 2'd2;

	// =====================================================
	// Memories and control registers
	reg [`HMDP_PM_W-1:0]   pm_mem [0:`HMDP_MEM_DEPTH-1];
	reg [`HMDP_DM_W-1:0]   dm_mem [0:`HMDP_MEM_DEPTH-1];
	reg [15:0]             port_overlay_select;
	reg [15:0]             short_read_timing_control;
	reg [`HMDP_ADDR_W-1:0] latched_start_address;
	reg                    sel_pm;
	reg                    pm_half;
	reg [15:0]             pm_upper;
	reg [1:0]              state;
	reg                    access_is_rd;
	reg                    rd_valid;
	reg                    rd_linger;
	reg                    boot_hold;
	reg                    mode_capture;
	reg [1:0]              strap_wait;
	reg                    sel_d;
	reg                    ial_d;
	reg                    rd_d;
	reg                    wr_d;

	wire [19:0] pin_sync;
	wire [2:0]  mode_sync;
	wire        sel_s;
	wire        ial_s;
	wire        rd_s;
	wire        wr_s;
	wire [15:0] bus_s;
	wire        latch_evt;
	wire        rd_evt;
	wire        wr_evt;
	wire        strobe_rel;

	function [`HMDP_ADDR_W-1:0] addr_inc;
		input [`HMDP_ADDR_W-1:0] a;
		begin
			addr_inc = a + 14'h0001;
		end
	endfunction

	// =====================================================
	// Pin synchronisers
	hmdp_sync #(.W(`HMDP_SYNC_W)) u_pin_sync
	(
		.core_clk (core_clk),
		.reset    (reset),
		.async_in ({~port_select_n, address_latch_strobe, ~port_read_strobe_n,
			~port_write_strobe_n, host_bus_in}),
		.sync_out (pin_sync)
	);

	hmdp_sync #(.W(3)) u_mode_sync
	(
		.core_clk (core_clk),
		.reset    (reset),
		.async_in ({mode_c, mode_b, mode_a}),
		.sync_out (mode_sync)
	);

	assign sel_s = pin_sync[19];
	assign ial_s = pin_sync[18];
	assign rd_s  = pin_sync[17];
	assign wr_s  = pin_sync[16];
	assign bus_s = pin_sync[15:0];

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			sel_d <= 1'b0;
			ial_d <= 1'b0;
			rd_d  <= 1'b0;
			wr_d  <= 1'b0;
		end
		else
		begin
			sel_d <= sel_s;
			ial_d <= ial_s;
			rd_d  <= rd_s;
			wr_d  <= wr_s;
		end
	end

	// =====================================================
	// Host events, taken only while acknowledged
	assign latch_evt  = (state == ST_IDLE) &&
		((ial_d && !ial_s && sel_s) || (sel_d && !sel_s && ial_s));
	assign rd_evt     = (state == ST_IDLE) && sel_s && rd_s && !rd_d && !ial_s;
	assign wr_evt     = (state == ST_IDLE) && sel_s && wr_s && !wr_d && !ial_s;
	assign strobe_rel = !(sel_s && (rd_s || wr_s));

	assign port_acknowledge = (state == ST_IDLE);
	assign core_wait        = (state == ST_ACCESS) && (core_wr || core_rd);
	assign core_run         = !boot_hold;
	assign host_bus_oe      = rd_valid || rd_linger;

	// =====================================================
	// Host sequencer and memory
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			state                     <= ST_IDLE;
			access_is_rd              <= 1'b0;
			latched_start_address     <= {`HMDP_ADDR_W{1'b0}};
			sel_pm                    <= 1'b0;
			pm_half                   <= 1'b0;
			pm_upper                  <= 16'h0000;
			port_overlay_select       <= `HMDP_OVL_RESET;
			short_read_timing_control <= `HMDP_TIM_RESET;
			host_bus_out              <= 16'h0000;
			core_rdata                <= 16'h0000;
			rd_valid                  <= 1'b0;
			rd_linger                 <= 1'b0;
			boot_hold                 <= 1'b0;
			mode_capture              <= 1'b1;
			strap_wait                <= 2'd0;
		end
		else
		begin
			// Strap caught once the synchroniser has filled
			if (mode_capture)
			begin
				if (strap_wait == `HMDP_STRAP_WAIT)
				begin
					mode_capture <= 1'b0;
					boot_hold    <= (mode_sync == `HMDP_BOOT_MODE);
				end
				else
					strap_wait <= strap_wait + 2'd1;
			end
			// Core side, control registers shared with the host side
			if (core_wr && !core_wait)
			begin
				if (core_addr == `HMDP_OVL_ADDR)
					port_overlay_select <= core_wdata;
				else if (core_addr == `HMDP_TIM_ADDR)
					short_read_timing_control <= core_wdata;
				else if (core_addr == `HMDP_SADDR_ADDR)
				begin
					latched_start_address <= core_wdata[`HMDP_ADDR_W-1:0];
					sel_pm                <= core_wdata[`HMDP_PMDM_BIT];
					pm_half               <= 1'b0;
				end
				else
					dm_mem[core_addr] <= core_wdata;
			end
			if (core_rd && !core_wait)
			begin
				if (core_addr == `HMDP_OVL_ADDR)
					core_rdata <= port_overlay_select;
				else if (core_addr == `HMDP_TIM_ADDR)
					core_rdata <= short_read_timing_control;
				else if (core_addr == `HMDP_SADDR_ADDR)
					core_rdata <= {1'b0, sel_pm, latched_start_address};
				else
					core_rdata <= dm_mem[core_addr];
			end
			// Host side
			case (state)
				ST_IDLE:
				begin
					if (latch_evt)
					begin
						if (bus_s[`HMDP_OVL_BIT])
							port_overlay_select <= {8'h00, bus_s[7:0]};
						else
						begin
							latched_start_address <= bus_s[`HMDP_ADDR_W-1:0];
							sel_pm                <= bus_s[`HMDP_PMDM_BIT];
							pm_half               <= 1'b0;
						end
					end
					else if (rd_evt || wr_evt)
					begin
						state        <= ST_ACCESS;
						access_is_rd <= rd_evt;
					end
				end
				ST_ACCESS:
				begin
					if (access_is_rd)
					begin
						// Upper 16 bits first, then low byte
						if (!sel_pm)
							host_bus_out <= dm_mem[latched_start_address];
						else if (!pm_half)
							host_bus_out <= pm_mem[latched_start_address][23:8];
						else
							host_bus_out <= {8'h00, pm_mem[latched_start_address][7:0]};
						rd_valid <= 1'b1;
					end
					else if (!sel_pm)
					begin
						if (latched_start_address < `HMDP_CTRL_BASE)
							dm_mem[latched_start_address] <= bus_s;
					end
					else if (!pm_half)
						pm_upper <= bus_s;
					else
					begin
						pm_mem[latched_start_address] <= {pm_upper, bus_s[7:0]};
						if (latched_start_address == {`HMDP_ADDR_W{1'b0}})
							boot_hold <= 1'b0;
					end
					if (!sel_pm || pm_half)
					begin
						latched_start_address <= addr_inc(latched_start_address);
						pm_half               <= 1'b0;
					end
					else
						pm_half <= 1'b1;
					state <= ST_REL;
				end
				ST_REL:
				begin
					if (strobe_rel)
						state <= ST_IDLE;
				end
				default:
					state <= ST_IDLE;
			endcase
			// Short read bus release
			if (rd_valid && !(sel_s && rd_s))
			begin
				rd_valid  <= 1'b0;
				rd_linger <= !short_read_timing_control[`HMDP_TIM_BIT];
			end
			else
				rd_linger <= 1'b0;
		end
	end

endmodule // hmdp_port

//--- hmdp_port_assertions.sv
// Pin relation checker for hmdp_port.
// Assumes a bind onto hmdp_port, one clock domain.
module hmdp_port_assertions
(
	input wire        core_clk,
	input wire        reset,
	input wire        port_select_n,
	input wire        port_read_strobe_n,
	input wire        port_write_strobe_n,
	input wire [15:0] host_bus_out,
	input wire        host_bus_oe,
	input wire        port_acknowledge,
	input wire        core_wr,
	input wire        core_rd,
	input wire        core_wait,
	input wire        core_run
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (reset);
oe_rise_a: assert property ($rose(host_bus_oe) |->
	$past(!port_select_n, 2) && $past(!port_read_strobe_n, 2)) else $error("oe without read");
ack_fall_a: assert property ($fell(port_acknowledge) |-> $past(!port_select_n, 2) &&
	!($past(port_read_strobe_n, 2) && $past(port_write_strobe_n, 2))) else $error("bad ack fall");
ack_rise_a: assert property ($rose(port_acknowledge) |-> $past(port_select_n) ||
	($past(port_read_strobe_n) && $past(port_write_strobe_n))) else $error("early ack");
ack_bound_a: assert property ($fell(port_acknowledge) |-> ##[1:40] port_acknowledge)
	else $error("ack stuck low");
oe_hold_a: assert property (host_bus_oe && !port_read_strobe_n && !port_select_n |=>
	host_bus_oe && $stable(host_bus_out)) else $error("read data dropped");
oe_drop_a: assert property (port_read_strobe_n [*7] |-> !host_bus_oe)
	else $error("bus not released");
core_wait_a: assert property (core_wait |->
	((core_wr || core_rd) && !port_acknowledge) ##1 !core_wait) else $error("wait too long");
run_rise_a: assert property ($rose(core_run) |->
	$past(!port_write_strobe_n, 2) && $past(!port_select_n, 2)) else $error("run without write");
endmodule // hmdp_port_assertions
bind hmdp_port hmdp_port_assertions hmdp_port_assertions_i (.core_clk(core_clk),
	.reset(reset), .port_select_n(port_select_n), .port_read_strobe_n(port_read_strobe_n),
	.port_write_strobe_n(port_write_strobe_n), .host_bus_out(host_bus_out),
	.host_bus_oe(host_bus_oe), .port_acknowledge(port_acknowledge), .core_wr(core_wr),
	.core_rd(core_rd), .core_wait(core_wait), .core_run(core_run));

//--- hmdp_host_model.sv
// Host processor model for the port pins.
// Assumes its tasks are called by the bench just after a clock edge.
module hmdp_host_model
(
	input  wire         core_clk,
	input  wire  [15:0] host_bus_out,
	input  wire         host_bus_oe,
	input  wire         port_acknowledge,
	output logic        port_select_n,
	output logic        address_latch_strobe,
	output logic        port_read_strobe_n,
	output logic        port_write_strobe_n,
	output wire  [15:0] host_bus_in
);
timeunit 1ns;
timeprecision 100ps;
logic [15:0] drv = 16'h0000;
logic        own = 0;
initial {port_select_n, address_latch_strobe, port_read_strobe_n, port_write_strobe_n} = 4'hb;
// Released bus shows the inverse of the last value
assign host_bus_in = host_bus_oe ? host_bus_out : own ? drv : ~drv;
task step;
	@(posedge core_clk);
	#1;
endtask
task wait_ack(bit v);
	while (port_acknowledge !== v)
		step;
endtask
task latch(logic [15:0] w);
	wait_ack(1);
	drv = w;
	own = 1;
	port_select_n = 0;
	address_latch_strobe = 1;
	repeat (3) step;
	address_latch_strobe = 0;
	repeat (3) step;
	port_select_n = 1;
	own = 0;
	step;
endtask
task acc(bit wr, logic [15:0] w, output logic [15:0] r);
	wait_ack(1);
	drv = w;
	own = wr;
	port_select_n = 0;
	port_write_strobe_n = !wr;
	port_read_strobe_n = wr;
	wait_ack(0);
	while (!wr && host_bus_oe !== 1)
		step;
	r = host_bus_out;
	// Read strobe held one more cycle over valid data
	if (!wr)
		step;
	{port_select_n, port_read_strobe_n, port_write_strobe_n} = 3'h7;
	own = 0;
	wait_ack(1);
	repeat (2) step;
endtask
endmodule // hmdp_host_model

//--- hmdp_port_test.sv
// Self-checking bench for hmdp_port.
// Assumes hmdp_host_model drives the host pins.
module hmdp_port_test;
timeunit 1ns;
timeprecision 100ps;
logic        core_clk = 0, reset = 1, mode_a = 1, mode_b = 0, mode_c = 1;
logic        core_wr = 0, core_rd = 0;
logic [13:0] core_addr = 14'h0000;
logic [15:0] core_wdata = 16'h0000, r, a, w, d [4];
logic [7:0]  b;
wire  [15:0] core_rdata, bin, bout;
wire         oe, ack, sel_n, als, rd_n, wr_n, core_wait, core_run;
int          fails = 0, compares = 0;
always #25 core_clk = ~core_clk;
hmdp_port hmdp_port_i (.core_clk(core_clk), .reset(reset), .port_select_n(sel_n),
	.address_latch_strobe(als), .port_read_strobe_n(rd_n), .port_write_strobe_n(wr_n),
	.host_bus_in(bin), .host_bus_out(bout), .host_bus_oe(oe), .port_acknowledge(ack),
	.mode_a(mode_a), .mode_b(mode_b), .mode_c(mode_c), .core_addr(core_addr),
	.core_wr(core_wr), .core_rd(core_rd), .core_wdata(core_wdata), .core_rdata(core_rdata),
	.core_wait(core_wait), .core_run(core_run));
hmdp_host_model hmdp_host_model_i (.core_clk(core_clk), .host_bus_out(bout),
	.host_bus_oe(oe), .port_acknowledge(ack), .port_select_n(sel_n),
	.address_latch_strobe(als), .port_read_strobe_n(rd_n), .port_write_strobe_n(wr_n),
	.host_bus_in(bin));
task chk(string n, logic [15:0] g, logic [15:0] e);
	compares++;
	if (g !== e)
	begin
		fails++;
		$display("CHECK FAILED %s expected %h seen %h", n, e, g);
	end
endtask
function automatic logic [15:0] pm_part(logic [23:0] word, bit lo);
	return lo ? {8'h00, word[7:0]} : word[23:8];
endfunction
task core(bit wr, logic [13:0] ad, logic [15:0] wd);
	@(posedge core_clk);
	#1 {core_addr, core_wr, core_rd, core_wdata} = {ad, wr, !wr, wd};
	@(posedge core_clk);
	#1 {core_wr, core_rd} = 2'b00;
endtask
task wrap_up;
	$display("compares %0d fails %0d", compares, fails);
	if (fails == 0 && compares > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
initial
begin
	#1500000;
	fails++;
	wrap_up;
end
initial
begin
	void'($urandom(7609));
	repeat (16) @(posedge core_clk);
	#1 reset = 0;
	repeat (3) @(posedge core_clk);
	#1 chk("run_held", core_run, 0);
	a = $urandom_range(16'h3f00);
	hmdp_host_model_i.latch(a);
	foreach (d[i])
	begin
		d[i] = $urandom;
		hmdp_host_model_i.acc(1, d[i], r);
	end
	foreach (d[i])
	begin
		core(0, a[13:0] + 14'(i), 0);
		chk("dm_core", core_rdata, d[i]);
	end
	hmdp_host_model_i.latch(a);
	foreach (d[i])
	begin
		hmdp_host_model_i.acc(0, 0, r);
		chk("dm_host", r, d[i]);
	end
	fork
		hmdp_host_model_i.acc(1, d[1], r);
		begin
			@(posedge core_clk);
			#1 {core_addr, core_rd} = {a[13:0] + 14'h4, 1'b1};
			repeat (12) @(posedge core_clk);
			#1 core_rd = 0;
		end
	join
	chk("core_during_host", core_rdata, d[1]);
	$display("test dm done");
	w = $urandom;
	b = $urandom;
	hmdp_host_model_i.latch(16'h4000);
	hmdp_host_model_i.acc(1, w, r);
	chk("run_half", core_run, 0);
	hmdp_host_model_i.acc(1, {8'h00, b}, r);
	chk("run_go", core_run, 1);
	hmdp_host_model_i.latch(16'h4000);
	hmdp_host_model_i.acc(0, 0, r);
	chk("pm_hi", r, pm_part({w, b}, 0));
	hmdp_host_model_i.acc(0, 0, r);
	chk("pm_lo", r, pm_part({w, b}, 1));
	$display("test pm boot done");
	core(1, 14'h3fe0, 16'hff00);
	hmdp_host_model_i.latch(16'h8000);
	core(0, 14'h3fe0, 0);
	chk("overlay", core_rdata, 16'h0000);
	hmdp_host_model_i.latch(16'h3fe7);
	hmdp_host_model_i.acc(1, 16'hffff, r);
	core(0, 14'h3fe7, 0);
	chk("ctrl_refused", core_rdata, 0);
	core(1, 14'h3fe7, 16'h4000);
	hmdp_host_model_i.latch(a);
	hmdp_host_model_i.acc(0, 0, r);
	chk("short_read", r, d[0]);
	core(1, 14'h3fe1, {2'b00, a[13:0] + 14'h2});
	hmdp_host_model_i.acc(0, 0, r);
	chk("core_start", r, d[2]);
	$display("test control done");
	wrap_up;
end
endmodule // hmdp_port_test
